//--- core/lpwm_core.sv
// led pwm core: level registers, intensity gating and open-drain pin control
`timescale 1ns/10ps

module lpwm_core #(
   parameter int OSC_DIV = lpwm_pkg::LPWM_OSC_DIV
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input lpwm_pkg::lpwm_reg_req_s reg_req_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input lpwm_pkg::lpwm_int_cfg_s int_cfg_i,
   input lpwm_pkg::lpwm_blink_cfg_s blink_cfg_i,
   output logic [lpwm_pkg::LPWM_NUM_OUT-1:0] pin_o,
   output logic [lpwm_pkg::LPWM_NUM_OUT-1:0] pin_oe_o,
   output logic pwm_running_o,
   output logic [7:0] phase_zero_o,
   output logic [7:0] phase_one_o
);
   import lpwm_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [7:0] phase_zero_ff;
   logic [7:0] phase_one_ff;
   logic [7:0] nxt_phase_zero;
   logic [7:0] nxt_phase_one;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic rvalid_ff;
   logic [LPWM_NUM_OUT-1:0] oe_ff;
   logic [LPWM_NUM_OUT-1:0] nxt_oe;
   logic [LPWM_NUM_OUT-1:0] pin_ff;
   logic running_ff;
   lpwm_pos_s pos;
   logic [LPWM_NUM_OUT-1:0][LPWM_INT_W-1:0] eff_int;
   logic [LPWM_NUM_OUT-1:0] level_zero;
   logic [LPWM_NUM_OUT-1:0] level_one;
   logic [LPWM_NUM_OUT-1:0] level_sel;
   logic [LPWM_NUM_OUT-1:0] out_static;
   logic [LPWM_NUM_OUT-1:0] out_on;
   logic [LPWM_NUM_OUT-1:0] out_level;

   // ----------------------------------------------------------------
   // register access decode
   // ----------------------------------------------------------------
   wire hit_zero = reg_req_i.addr == LPWM_ADDR_PHASE_ZERO;
   wire hit_one = reg_req_i.addr == LPWM_ADDR_PHASE_ONE;
   wire wr_zero = reg_req_i.wr && hit_zero;
   wire wr_one = reg_req_i.wr && hit_one;

   // writes store the whole byte; other addresses belong to neighbouring blocks
   assign nxt_phase_zero = wr_zero ? reg_req_i.wdata : phase_zero_ff;
   assign nxt_phase_one = wr_one ? reg_req_i.wdata : phase_one_ff;

   // read mux, unmapped addresses answer zero so a shared read bus can or them
   assign nxt_rdata = !reg_req_i.rd ? rdata_ff :
                      hit_zero ? phase_zero_ff :
                      hit_one ? phase_one_ff :
                      LPWM_RDATA_NONE;

   // level and read-back registers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phase_zero_ff <= LPWM_LEVEL_RST;
         phase_one_ff <= LPWM_LEVEL_RST;
         rdata_ff <= LPWM_RDATA_NONE;
         rvalid_ff <= 1'b0;
      end else begin
         phase_zero_ff <= nxt_phase_zero;
         phase_one_ff <= nxt_phase_one;
         rdata_ff <= nxt_rdata;
         rvalid_ff <= reg_req_i.rd;
      end
   end

   // ----------------------------------------------------------------
   // intensity mode selection
   // ----------------------------------------------------------------
   // master codes 0x00..0x0F switch the whole pwm engine off
   wire pwm_mode = int_cfg_i.master >= LPWM_MASTER_PWM_MIN;
   wire [LPWM_INT_W-1:0] master_slots;
   wire [LPWM_INT_W-1:0] ninth_int;
   // upper nibble counts gated slots, lower nibble is the ninth/global setting
   assign {master_slots, ninth_int} = int_cfg_i.master;

   // global flag replaces every setting by one value, never a subset
   generate
      for (genvar n = 0; n < LPWM_NUM_OUT; n++) begin : g_int
         if (n == LPWM_NINTH) begin : g_ninth
            assign eff_int[n] = ninth_int;
         end else begin : g_bank
            assign eff_int[n] = int_cfg_i.global_en ? ninth_int :
                                int_cfg_i.indiv[n];
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // oscillator gating
   // ----------------------------------------------------------------
   // every output static means the oscillator can stop to save current
   wire all_static = !pwm_mode || (out_static == '1);
   wire run = !all_static;

   // step position within the 240-step period
   lpwm_timebase #(
      .OSC_DIV(OSC_DIV)
   ) u_timebase (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .run_i(run),
      .pos_o(pos)
   );

   // ----------------------------------------------------------------
   // level selection per output
   // ----------------------------------------------------------------
   // ninth output levels come from the configuration block
   assign level_zero = {blink_cfg_i.ninth_zero, phase_zero_ff};
   assign level_one = {blink_cfg_i.ninth_one, phase_one_ff};

   // blink off always uses phase zero; blink on follows the phase select
   assign level_sel = (blink_cfg_i.enable && blink_cfg_i.phase) ? level_one :
                      level_zero;

   // ----------------------------------------------------------------
   // pwm on-time per output
   // ----------------------------------------------------------------
   // the gate opens for master_slots of the 15 slots; duty inside a slot is
   // setting+1 sixteenths, so off-time is never empty unless static
   wire gate_open = pos.slot < master_slots;

   generate
      for (genvar n = 0; n < LPWM_NUM_OUT; n++) begin : g_out
         assign out_static[n] = !pwm_mode ||
                                (eff_int[n] == LPWM_INT_STATIC);
         assign out_on[n] = gate_open && (pos.cycle <= eff_int[n]);
         // on-time shows the level bit, off-time its complement
         assign out_level[n] = out_static[n] ? level_sel[n] :
                               (out_on[n] ? level_sel[n] : !level_sel[n]);
      end
   endgenerate

   // level zero sinks current, level one releases the open-drain pin
   assign nxt_oe = ~out_level;

   // ----------------------------------------------------------------
   // pin registers
   // ----------------------------------------------------------------
   // registered pins keep the static outputs free of decode glitches
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         oe_ff <= '0;
         pin_ff <= '0;
         running_ff <= 1'b0;
      end else begin
         oe_ff <= nxt_oe;
         pin_ff <= {LPWM_NUM_OUT{LPWM_PIN_DRIVE[0]}};
         running_ff <= run;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign pin_o = pin_ff;
   assign pin_oe_o = oe_ff;
   assign pwm_running_o = running_ff;
   assign reg_rdata_o = rdata_ff;
   assign reg_rvalid_o = rvalid_ff;
   assign phase_zero_o = phase_zero_ff;
   assign phase_one_o = phase_one_ff;

endmodule : lpwm_core

//--- core/lpwm_timebase.sv
// pwm timebase: gated 32 kHz step generator and period position counter
`timescale 1ns/10ps
module lpwm_timebase #(
   parameter int OSC_DIV = lpwm_pkg::LPWM_OSC_DIV
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic run_i,
   output lpwm_pkg::lpwm_pos_s pos_o
);
   import lpwm_pkg::*;

   // ----------------------------------------------------------------
   // oscillator model and step counter
   // ----------------------------------------------------------------
   localparam logic [LPWM_DIV_W-1:0] DIV_LAST = LPWM_DIV_W'(OSC_DIV - 1);

   logic [LPWM_DIV_W-1:0] div_ff;
   logic [LPWM_DIV_W-1:0] nxt_div;
   lpwm_pos_s pos_ff;
   lpwm_pos_s nxt_pos;
   wire step = run_i && (div_ff == DIV_LAST);
   wire slot_end = pos_ff.cycle == LPWM_LAST_CYCLE;
   wire period_end = slot_end && (pos_ff.slot == LPWM_LAST_SLOT);

   // stopped oscillator holds at the period start, so restart is deterministic
   assign nxt_div = !run_i ? '0 : (step ? '0 : div_ff + 1'b1);

   // 16 cycles per slot, 15 slots per period: 240 steps
   always_comb begin
      nxt_pos = pos_ff;
      if (!run_i) begin
         nxt_pos = '0;
      end else if (step) begin
         nxt_pos.cycle = pos_ff.cycle + 1'b1;
         if (period_end) begin
            nxt_pos.slot = '0;
         end else if (slot_end) begin
            nxt_pos.slot = pos_ff.slot + 1'b1;
         end
      end
   end

   // state registers
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_ff <= '0;
         pos_ff <= '0;
      end else begin
         div_ff <= nxt_div;
         pos_ff <= nxt_pos;
      end
   end

   assign pos_o = pos_ff;

endmodule : lpwm_timebase

//--- include/lpwm_pkg.sv
// package: constants, register map and carrier types for the led pwm output block
package lpwm_pkg;

   // ----------------------------------------------------------------
   // register map of the level registers
   // ----------------------------------------------------------------
   localparam logic [7:0] LPWM_ADDR_PHASE_ZERO = 8'h01;
   localparam logic [7:0] LPWM_ADDR_PHASE_ONE = 8'h09;
   localparam logic [7:0] LPWM_LEVEL_RST = 8'hFF;   // outputs 0..7 released after reset
   localparam logic [7:0] LPWM_RDATA_NONE = 8'h00;  // answer to an unmapped read

   // ----------------------------------------------------------------
   // output and intensity layout
   // ----------------------------------------------------------------
   localparam int LPWM_NUM_OUT = 9;
   localparam int LPWM_NUM_BANK = 8;
   localparam int LPWM_NINTH = 8;
   localparam int LPWM_INT_W = 4;
   localparam logic [7:0] LPWM_MASTER_PWM_MIN = 8'h10;  // below this every output is static
   localparam logic [3:0] LPWM_INT_STATIC = 4'hF;       // 16/16 setting
   localparam logic [3:0] LPWM_LAST_CYCLE = 4'hF;       // 16 pwm cycles per timeslot
   localparam logic [3:0] LPWM_LAST_SLOT = 4'hE;        // 15 timeslots per period
   localparam logic [3:0] LPWM_PIN_DRIVE = 4'h0;

   // ----------------------------------------------------------------
   // timing: pwm step rate taken from the 32 kHz oscillator
   // ----------------------------------------------------------------
   localparam int LPWM_CLK_HZ = 200_000_000;
   localparam int LPWM_OSC_HZ = 32_000;
   localparam int LPWM_OSC_DIV = LPWM_CLK_HZ / LPWM_OSC_HZ;  // rounds down, 6250 cycles
   localparam int LPWM_DIV_W = 16;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lpwm_reg_req_s;

   typedef struct packed {
      logic [7:0] master;                                   // master / ninth output intensity
      logic global_en;                                      // global intensity flag
      logic [LPWM_NUM_BANK-1:0][LPWM_INT_W-1:0] indiv;      // individual intensities, outputs 0..7
   } lpwm_int_cfg_s;

   typedef struct packed {
      logic enable;         // blink enable
      logic phase;          // selected blink phase, flip already applied
      logic ninth_zero;     // ninth output level, phase zero
      logic ninth_one;      // ninth output level, phase one
   } lpwm_blink_cfg_s;

   typedef struct packed {
      logic [3:0] slot;     // master timeslot 0..14
      logic [3:0] cycle;    // pwm cycle within slot 0..15
   } lpwm_pos_s;

endpackage : lpwm_pkg

//--- testbench/lpwm_core_sva.sv
// checker: register port and static level relations of the led pwm core
`timescale 1ns/10ps
module lpwm_core_sva import lpwm_pkg::*; #(
   parameter int OSC_DIV = LPWM_OSC_DIV
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input lpwm_pkg::lpwm_reg_req_s reg_req_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input lpwm_pkg::lpwm_int_cfg_s int_cfg_i,
   input lpwm_pkg::lpwm_blink_cfg_s blink_cfg_i,
   input wire logic [8:0] pin_o,
   input wire logic [8:0] pin_oe_o,
   input wire logic pwm_running_o,
   input wire logic [7:0] phase_zero_o,
   input wire logic [7:0] phase_one_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // selected levels and static conditions, as the pins should see them
   wire logic ph1 = blink_cfg_i.enable && blink_cfg_i.phase;
   wire logic [7:0] sel_lvl = ph1 ? phase_one_o : phase_zero_o;
   wire logic sel_n9 = ph1 ? blink_cfg_i.ninth_one : blink_cfg_i.ninth_zero;
   wire logic stat_all = int_cfg_i.master < LPWM_MASTER_PWM_MIN;
   wire logic [3:0] set0 = int_cfg_i.global_en ? int_cfg_i.master[3:0] : int_cfg_i.indiv[0];
   wire logic stat0 = set0 == LPWM_INT_STATIC;
   rvalid_tie_a: assert property (reg_rvalid_o == $past(reg_req_i.rd)) else $error("rvalid wrong");
   rd_zero_a: assert property (reg_req_i.rd && reg_req_i.addr == LPWM_ADDR_PHASE_ZERO
      |=> reg_rdata_o == $past(phase_zero_o)) else $error("phase zero read wrong");
   rd_one_a: assert property (reg_req_i.rd && reg_req_i.addr == LPWM_ADDR_PHASE_ONE
      |=> reg_rdata_o == $past(phase_one_o)) else $error("phase one read wrong");
   wr_zero_a: assert property (reg_req_i.wr && reg_req_i.addr == LPWM_ADDR_PHASE_ZERO
      |=> phase_zero_o == $past(reg_req_i.wdata)) else $error("phase zero write lost");
   wr_one_a: assert property (reg_req_i.wr && reg_req_i.addr == LPWM_ADDR_PHASE_ONE
      |=> phase_one_o == $past(reg_req_i.wdata)) else $error("phase one write lost");
   static_lvl_a: assert property (stat_all |=> pin_oe_o[7:0] == ~$past(sel_lvl))
      else $error("static bank level wrong");
   ninth_lvl_a: assert property (stat_all |=> pin_oe_o[8] == ~$past(sel_n9)) else $error("ninth wrong");
   full_duty_a: assert property (!stat_all && stat0 |=> pin_oe_o[0] == ~$past(sel_lvl[0]))
      else $error("full setting not static");
   osc_off_a: assert property (stat_all [*2] |=> !pwm_running_o) else $error("oscillator runs");
   osc_on_a: assert property ((!stat_all && !stat0) [*2] |=> pwm_running_o) else $error("oscillator idle");
endmodule : lpwm_core_sva

bind lpwm_core lpwm_core_sva #(.OSC_DIV(OSC_DIV)) chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .reg_req_i(reg_req_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .int_cfg_i(int_cfg_i), .blink_cfg_i(blink_cfg_i),
   .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pwm_running_o(pwm_running_o), .phase_zero_o(phase_zero_o),
   .phase_one_o(phase_one_o));

//--- testbench/lpwm_led_load.sv
// led load model: pulled-up open-drain lines with lit-cycle counters
`timescale 1ns/10ps
module lpwm_led_load (
   input wire logic clk_i,
   input wire logic clr_i,
   input wire logic [8:0] pin_i,
   input wire logic [8:0] pin_oe_i,
   output logic [8:0] line_o,
   output logic [31:0] lit_o [9]
);
   // a released line floats up to the pull-up level, never keeps its last value
   assign line_o = (pin_oe_i & pin_i) | ~pin_oe_i;
   // led lit while its line is low; clear before each measured period
   // a 4-state count lets an unknown line show up as a mismatch, not as unlit
   always @(posedge clk_i)
      for (int n = 0; n < 9; n++)
         lit_o[n] <= clr_i ? 32'h0000_0000 : lit_o[n] + {31'h0000_0000, !line_o[n]};
endmodule : lpwm_led_load

//--- testbench/tb_top.sv
// testbench: registers, static levels and pwm duty of the led pwm core
`timescale 1ns/10ps
module tb_top;
   import lpwm_pkg::*;
   localparam int OSC = 4; // short step keeps one period at 960 cycles
   localparam int PER = 240 * OSC;
   localparam logic [8:0] CASES [6] = '{9'h003, 9'h010, 9'h0fe, 9'h0ff, 9'h110, 9'h18f};
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic clr = 1'b1;
   lpwm_reg_req_s req = '0;
   lpwm_int_cfg_s icfg = '0;
   lpwm_blink_cfg_s bcfg = '0;
   logic [7:0] rdata, pz, po;
   logic rvalid, run;
   logic [8:0] pin, oe, line;
   logic [31:0] lit [9];
   int errors = 0;
   int cmp_count = 0;
   initial forever #2.5 clk_i = ~clk_i;
   lpwm_core #(.OSC_DIV(OSC)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .reg_req_i(req), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .int_cfg_i(icfg), .blink_cfg_i(bcfg), .pin_o(pin), .pin_oe_o(oe),
      .pwm_running_o(run), .phase_zero_o(pz), .phase_one_o(po));
   lpwm_led_load led_u (.clk_i(clk_i), .clr_i(clr), .pin_i(pin), .pin_oe_i(oe), .line_o(line), .lit_o(lit));
   // ------------------------------------------------
   // shared tasks and expectations
   // ------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // one gap cycle after each access, so a strobe is never set and cleared in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk_i);
      req <= '0;
      @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_i);
      req <= '0;
      #1 check({rvalid, rdata}, {1'b1, e});
      @(posedge clk_i);
   endtask : rd
   // lit cycles in one period: on-steps drive the level, off-steps its complement
   function automatic int exp_lit(input logic [3:0] m, input logic [3:0] s, input logic l);
      int on = (m == 4'h0 || s == 4'hf) ? PER : OSC * m * (s + 1);
      return l ? PER - on : on;
   endfunction : exp_lit
   task automatic blink_case(input logic en, input logic ph);
      logic [7:0] a, b;
      logic [1:0] n9;
      a = 8'($urandom);
      b = 8'($urandom);
      n9 = 2'($urandom);
      wr(LPWM_ADDR_PHASE_ZERO, a);
      wr(LPWM_ADDR_PHASE_ONE, b);
      icfg <= '{8'h05, 1'b1, 32'($urandom)};
      bcfg <= '{en, ph, n9[0], n9[1]};
      repeat (3) @(posedge clk_i);
      #1 check(line, (en && ph) ? {n9[1], b} : {n9[0], a});
      check(run, 1'b0);
      @(posedge clk_i);
   endtask : blink_case
   task automatic pwm_case(input logic [3:0] m, input logic [3:0] s, input logic g);
      logic [7:0] lv;
      logic nz;
      lv = 8'($urandom);
      nz = 1'($urandom);
      wr(LPWM_ADDR_PHASE_ZERO, lv);
      icfg <= '{{m, s}, g, g ? 32'($urandom) : {8{s}}};
      bcfg <= '{1'b0, 1'($urandom), nz, 1'($urandom)};
      repeat (4) @(posedge clk_i);
      clr <= 1'b0;
      repeat (PER) @(posedge clk_i);
      #1 check(run, m != 4'h0 && s != 4'hf);
      for (int n = 0; n < 9; n++)
         check(lit[n], exp_lit(m, s, n < 8 ? lv[n] : nz));
      @(posedge clk_i);
      clr <= 1'b1;
   endtask : pwm_case
   // main sequence
   initial begin
      logic [7:0] d;
      void'($urandom(32'h0000_f97a));
      repeat (5) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      rd(LPWM_ADDR_PHASE_ZERO, LPWM_LEVEL_RST);
      rd(LPWM_ADDR_PHASE_ONE, LPWM_LEVEL_RST);
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         wr(LPWM_ADDR_PHASE_ZERO, d);
         wr(LPWM_ADDR_PHASE_ONE, ~d);
         rd(LPWM_ADDR_PHASE_ZERO, d);
         rd(LPWM_ADDR_PHASE_ONE, ~d);
      end
      wr(8'h05, ~d);
      rd(8'h05, LPWM_RDATA_NONE);
      rd(LPWM_ADDR_PHASE_ZERO, d);
      $display("register test done");
      for (int i = 0; i < 4; i++)
         blink_case(i[1], i[0]);
      $display("blink level test done");
      for (int i = 0; i < 6; i++)
         pwm_case(CASES[i][7:4], CASES[i][3:0], CASES[i][8]);
      repeat (6) pwm_case(4'($urandom), 4'($urandom), 1'($urandom));
      $display("pwm duty test done");
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      rd(LPWM_ADDR_PHASE_ZERO, LPWM_LEVEL_RST);
      $display("second reset test done");
      final_report();
   end
   // watchdog: tests need about 11700 cycles
   initial begin
      repeat (30_000) @(posedge clk_i);
      errors++;
      final_report();
   end
endmodule : tb_top
